/* File: rtl/emo_pkg.sv */
// package: opcodes, register map, state encoding and state record of the edit engine
package emo_pkg;

  // ****************************************************
  // micro-operator codes
  // ****************************************************
  localparam logic [7:0] OP_MOVE_WITH_INSERT         = 8'hD0;
  localparam logic [7:0] OP_MOVE_WITH_FLOAT          = 8'hD1;
  localparam logic [7:0] OP_SKIP_FORWARD_SOURCE      = 8'hD2;
  localparam logic [7:0] OP_SKIP_REVERSE_SOURCE      = 8'hD3;
  localparam logic [7:0] OP_RESET_FLOAT              = 8'hD4;
  localparam logic [7:0] OP_END_FLOAT                = 8'hD5;
  localparam logic [7:0] OP_MOVE_NUMERIC             = 8'hD6;
  localparam logic [7:0] OP_MOVE_CHARACTERS          = 8'hD7;
  localparam logic [7:0] OP_INSERT_OVERPUNCH         = 8'hD8;
  localparam logic [7:0] OP_INSERT_DISPLAY_SIGN      = 8'hD9;
  localparam logic [7:0] OP_SKIP_FORWARD_DESTINATION = 8'hDA;
  localparam logic [7:0] OP_SKIP_REVERSE_DESTINATION = 8'hDB;
  localparam logic [7:0] OP_INSERT_UNCONDITIONAL     = 8'hDC;
  localparam logic [7:0] OP_INSERT_CONDITIONAL       = 8'hDD;
  localparam logic [7:0] OP_END_EDIT                 = 8'hDE;

  // ****************************************************
  // character zones
  // ****************************************************
  localparam logic [3:0] ZONE_NUMERIC_8   = 4'hF;
  localparam logic [3:0] ZONE_NUMERIC_4   = 4'h0;
  localparam logic [3:0] ZONE_OVERPUNCH   = 4'hD;

  // ****************************************************
  // register map (byte addresses)
  // ****************************************************
  localparam logic [4:0] REG_CTRL    = 5'h00;
  localparam logic [4:0] REG_REPEAT  = 5'h04;
  localparam logic [4:0] REG_SRCPTR  = 5'h08;
  localparam logic [4:0] REG_DSTPTR  = 5'h0C;
  localparam logic [4:0] REG_STATUS  = 5'h10;
  localparam logic [4:0] REG_INTSTAT = 5'h14;
  localparam logic [4:0] REG_INTMASK = 5'h18;

  // ctrl bits
  localparam int CTRL_GO    = 0;
  localparam int CTRL_TABLE = 1;
  localparam int CTRL_DST8  = 2;
  localparam int CTRL_XSIGN = 3;
  localparam int CTRL_FLOAT = 4;

  // interrupt status bits
  localparam int INT_PROTECT = 0;
  localparam int INT_OPDONE  = 1;
  localparam int INT_ENDEDIT = 2;
  localparam int INT_BADOP   = 3;

  localparam logic [3:0] INTMASK_RST = 4'h0;
  localparam logic [19:0] PTR_RST    = 20'h00000;

  // ****************************************************
  // sequencer states and state record
  // ****************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_OPC  = 3'b001,
    ST_ARG  = 3'b010,
    ST_EXEC = 3'b011,
    ST_RDW  = 3'b100,
    ST_WRW  = 3'b101
  } emo_state_t;

  typedef struct packed {
    emo_state_t       st;
    logic             tableMode;
    logic             dst8;
    logic             extSign;
    logic             float;
    logic [7:0]       op;
    logic [3:0][7:0]  arg;
    logic [2:0]       argNeed;
    logic [2:0]       argIdx;
    logic [19:0]      count;
    logic [19:0]      repeatVal;
    logic [19:0]      srcPtr;
    logic [19:0]      dstPtr;
    logic [7:0]       curChar;
    logic             pendNum;
    logic             rdDst;
    logic             sylReq;
    logic             memRdReq;
    logic [19:0]      memRdAddr;
    logic             memWrEn;
    logic [19:0]      memWrAddr;
    logic [7:0]       memWrData;
    logic [31:0]      busRdData;
    logic [3:0]       intStat;
    logic [3:0]       intMask;
    logic             irq;
  } emo_regs_t;

endpackage

/* File: rtl/emo_engine.sv */
// edit micro-operator engine: sequencer, operand fetch, string moves and register port
`timescale 1ns/10ps

// Contract
// - protected source or destination word aborts, interrupts
// - move characters: count from syllable or repeat register
// - numeric move copies low nibble, zone ones for 8-bit destination, zeros otherwise
// - move with insert: count and character sources
// - insert on zero digit while float clear, else float set
// - move with float takes three insert characters
// - float clear: zero inserts, nonzero writes sign
// - float set writes numeric; repeat exact count
// - forward source skip, count by mode
// - reverse source skip, same count source
// - destination skips: DA forward, DB back
// - reset float clears float only
// - end float: sign char or clear float
// - unconditional insert repeats one character
// - conditional insert picks by float
// - display sign picks character by sign
// - overpunch zone when sign is one
// - end edit terminates table execution
module emo_engine
  import emo_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  // register port
  input  wire logic [4:0]  busAddr,
  input  wire logic [31:0] busWrData,
  input  wire logic        busWrStb,
  input  wire logic        busRdStb,
  output logic      [31:0] busRdData,
  // program syllable stream
  output logic             sylReq,
  input  wire logic        sylValid,
  input  wire logic [7:0]  sylData,
  // string memory
  output logic             memRdReq,
  output logic      [19:0] memRdAddr,
  input  wire logic        memRdValid,
  input  wire logic [7:0]  memRdData,
  input  wire logic        memRdProtect,
  output logic             memWrEn,
  output logic      [19:0] memWrAddr,
  output logic      [7:0]  memWrData,
  input  wire logic        memWrAck,
  input  wire logic        memWrProtect,
  // interrupt
  output logic             irq
);

  emo_regs_t q;
  emo_regs_t d;

  // ****************************************************
  // decode helpers
  // ****************************************************
  function automatic logic hasCount(input logic [7:0] op);
    case (op)
      OP_MOVE_WITH_INSERT, OP_MOVE_WITH_FLOAT, OP_SKIP_FORWARD_SOURCE,
      OP_SKIP_REVERSE_SOURCE, OP_MOVE_NUMERIC, OP_MOVE_CHARACTERS,
      OP_SKIP_FORWARD_DESTINATION, OP_SKIP_REVERSE_DESTINATION,
      OP_INSERT_UNCONDITIONAL, OP_INSERT_CONDITIONAL: hasCount = 1'b1;
      default: hasCount = 1'b0;
    endcase
  endfunction

  function automatic logic [2:0] charArgs(input logic [7:0] op);
    case (op)
      OP_MOVE_WITH_INSERT, OP_INSERT_UNCONDITIONAL: charArgs = 3'h1;
      OP_MOVE_WITH_FLOAT: charArgs = 3'h3;
      OP_END_FLOAT, OP_INSERT_DISPLAY_SIGN, OP_INSERT_CONDITIONAL: charArgs = 3'h2;
      default: charArgs = 3'h0;
    endcase
  endfunction

  function automatic logic knownOp(input logic [7:0] op);
    knownOp = (op[7:4] == 4'hD) && (op[3:0] != 4'hF);
  endfunction

  // numeric form of a character for the configured destination width
  function automatic logic [7:0] numForm(input logic [7:0] c, input logic dst8);
    numForm = {(dst8 ? ZONE_NUMERIC_8 : ZONE_NUMERIC_4), c[3:0]};
  endfunction

  function automatic logic digitZero(input logic [7:0] c);
    digitZero = (c[3:0] == 4'h0);
  endfunction

  // ****************************************************
  // next state
  // ****************************************************
  always_comb begin
    logic            finish;
    logic            doWrite;
    logic [7:0]      wChar;
    logic [3:0][7:0] a;
    logic [3:0]      setEv;
    d       = q;
    finish  = 1'b0;
    doWrite = 1'b0;
    wChar   = 8'h00;
    a       = q.arg;
    setEv   = 4'h0;
    d.memRdReq  = 1'b0;
    d.memWrEn   = 1'b0;
    d.busRdData = 32'h0000_0000;

    // register writes
    if (busWrStb) begin
      case (busAddr)
        REG_CTRL: begin
          if (q.st == ST_IDLE) begin
            d.tableMode = busWrData[CTRL_TABLE];
            d.dst8      = busWrData[CTRL_DST8];
            d.extSign   = busWrData[CTRL_XSIGN];
            d.float     = busWrData[CTRL_FLOAT];
            if (busWrData[CTRL_GO]) begin
              d.st     = ST_OPC;
              d.sylReq = 1'b1;
            end
          end
        end
        REG_REPEAT: if (q.st == ST_IDLE) d.repeatVal = busWrData[19:0];
        REG_SRCPTR: if (q.st == ST_IDLE) d.srcPtr = busWrData[19:0];
        REG_DSTPTR: if (q.st == ST_IDLE) d.dstPtr = busWrData[19:0];
        REG_INTSTAT: d.intStat = q.intStat & ~busWrData[3:0];
        REG_INTMASK: d.intMask = busWrData[3:0];
        default: ;
      endcase
    end

    // sequencer
    case (q.st)
      ST_IDLE: ;
      ST_OPC: begin
        if (sylValid) begin
          d.op      = sylData;
          d.argIdx  = 3'h0;
          d.argNeed = charArgs(sylData) + {2'b00, q.tableMode & hasCount(sylData)};
          d.pendNum = 1'b0;
          if (sylData == OP_END_EDIT) begin
            setEv[INT_ENDEDIT] = 1'b1;
            d.st     = ST_IDLE;
            d.sylReq = 1'b0;
          end else if (!knownOp(sylData)) begin
            setEv[INT_BADOP] = 1'b1;
            d.st     = ST_IDLE;
            d.sylReq = 1'b0;
          end else if (d.argNeed == 3'h0) begin
            d.st     = ST_EXEC;
            d.sylReq = 1'b0;
            d.count  = hasCount(sylData) ? q.repeatVal : 20'h00001;
          end else begin
            d.st = ST_ARG;
          end
        end
      end
      ST_ARG: begin
        if (sylValid) begin
          a[q.argIdx] = sylData;
          d.argIdx    = q.argIdx + 3'h1;
          d.arg       = a;
          if (d.argIdx == q.argNeed) begin
            d.st     = ST_EXEC;
            d.sylReq = 1'b0;
            // table mode: count syllable first, characters after it
            if (q.tableMode && hasCount(q.op)) begin
              d.count = {12'h000, a[0]};
              d.arg   = {8'h00, a[3:1]};
            end else if (hasCount(q.op)) begin
              d.count = q.repeatVal;
            end else begin
              d.count = 20'h00001;
            end
          end
        end
      end
      ST_EXEC: begin
        case (q.op)
          OP_SKIP_FORWARD_SOURCE: begin
            d.srcPtr = q.srcPtr + q.count;
            finish   = 1'b1;
          end
          OP_SKIP_REVERSE_SOURCE: begin
            d.srcPtr = q.srcPtr - q.count;
            finish   = 1'b1;
          end
          OP_SKIP_FORWARD_DESTINATION: begin
            d.dstPtr = q.dstPtr + q.count;
            finish   = 1'b1;
          end
          OP_SKIP_REVERSE_DESTINATION: begin
            d.dstPtr = q.dstPtr - q.count;
            finish   = 1'b1;
          end
          OP_RESET_FLOAT: begin
            d.float = 1'b0;
            finish  = 1'b1;
          end
          OP_END_FLOAT: begin
            if (q.float) begin
              d.float = 1'b0;
              finish  = 1'b1;
            end else if (q.count == 20'h00000) begin
              finish = 1'b1;
            end else begin
              doWrite = 1'b1;
              wChar   = q.extSign ? q.arg[0] : q.arg[1];
            end
          end
          OP_INSERT_DISPLAY_SIGN: begin
            if (q.count == 20'h00000) begin
              finish = 1'b1;
            end else begin
              doWrite = 1'b1;
              wChar   = q.extSign ? q.arg[0] : q.arg[1];
            end
          end
          OP_INSERT_UNCONDITIONAL, OP_INSERT_CONDITIONAL: begin
            if (q.count == 20'h00000) begin
              finish = 1'b1;
            end else begin
              doWrite = 1'b1;
              wChar   = q.arg[0];
              if (q.op == OP_INSERT_CONDITIONAL) begin
                wChar = q.float ? q.arg[1] : q.arg[0];
              end
            end
          end
          OP_INSERT_OVERPUNCH: begin
            // sign zone lands on the last character already written
            if (!q.extSign || q.count == 20'h00000) begin
              finish = 1'b1;
            end else begin
              d.memRdReq  = 1'b1;
              d.memRdAddr = q.dstPtr - 20'h00001;
              d.rdDst     = 1'b1;
              d.st        = ST_RDW;
            end
          end
          default: begin
            // the moves: read a source character, or finish the digit after a sign
            if (q.pendNum) begin
              doWrite = 1'b1;
              wChar   = numForm(q.curChar, q.dst8);
            end else if (q.count == 20'h00000) begin
              finish = 1'b1;
            end else begin
              d.memRdReq  = 1'b1;
              d.memRdAddr = q.srcPtr;
              d.rdDst     = 1'b0;
              d.st        = ST_RDW;
            end
          end
        endcase
      end
      ST_RDW: begin
        if (memRdValid) begin
          if (memRdProtect) begin
            setEv[INT_PROTECT] = 1'b1;
            d.st = ST_IDLE;
          end else if (q.rdDst) begin
            doWrite = 1'b1;
            wChar   = {ZONE_OVERPUNCH, memRdData[3:0]};
          end else begin
            d.srcPtr  = q.srcPtr + 20'h00001;
            doWrite   = 1'b1;
            d.curChar = memRdData;
            case (q.op)
              OP_MOVE_CHARACTERS: wChar = memRdData;
              OP_MOVE_NUMERIC: wChar = numForm(memRdData, q.dst8);
              OP_MOVE_WITH_INSERT: begin
                if (!q.float && digitZero(memRdData)) begin
                  wChar = q.arg[0];
                end else begin
                  d.float = 1'b1;
                  wChar   = numForm(memRdData, q.dst8);
                end
              end
              default: begin
                if (q.float) begin
                  wChar = numForm(memRdData, q.dst8);
                end else if (digitZero(memRdData)) begin
                  wChar = q.arg[0];
                end else begin
                  d.float   = 1'b1;
                  d.pendNum = 1'b1;
                  wChar     = q.extSign ? q.arg[1] : q.arg[2];
                end
              end
            endcase
          end
        end
      end
      ST_WRW: begin
        if (memWrAck) begin
          if (memWrProtect) begin
            setEv[INT_PROTECT] = 1'b1;
            d.st = ST_IDLE;
          end else begin
            d.st = ST_EXEC;
            // a sign character does not consume the repeat count
            if (!q.pendNum) begin
              d.count = q.count - 20'h00001;
            end
          end
        end
      end
      default: d.st = ST_IDLE;
    endcase

    // issue one destination write
    if (doWrite) begin
      d.memWrEn   = 1'b1;
      d.memWrData = wChar;
      d.st        = ST_WRW;
      if (q.st == ST_RDW && q.rdDst) begin
        d.memWrAddr = q.dstPtr - 20'h00001;
      end else begin
        d.memWrAddr = q.dstPtr;
        d.dstPtr    = q.dstPtr + 20'h00001;
      end
      if (q.st == ST_EXEC && q.pendNum) begin
        d.pendNum = 1'b0;
      end
    end

    // one operation done: table mode fetches the next opcode
    if (finish) begin
      setEv[INT_OPDONE] = 1'b1;
      d.st     = q.tableMode ? ST_OPC : ST_IDLE;
      d.sylReq = q.tableMode;
    end

    // set beats a simultaneous write-one clear
    d.intStat = d.intStat | setEv;
    d.irq     = |(d.intStat & d.intMask);

    // register reads
    if (busRdStb) begin
      case (busAddr)
        REG_CTRL:    d.busRdData = {27'h0, q.float, q.extSign, q.dst8, q.tableMode, 1'b0};
        REG_REPEAT:  d.busRdData = {12'h000, q.repeatVal};
        REG_SRCPTR:  d.busRdData = {12'h000, q.srcPtr};
        REG_DSTPTR:  d.busRdData = {12'h000, q.dstPtr};
        REG_STATUS:  d.busRdData = {16'h0000, q.op, 4'h0, q.st, (q.st != ST_IDLE)};
        REG_INTSTAT: d.busRdData = {28'h0000000, q.intStat};
        REG_INTMASK: d.busRdData = {28'h0000000, q.intMask};
        default:     d.busRdData = 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************
  // state register
  // ****************************************************
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      q         <= '0;
      q.st      <= ST_IDLE;
      q.srcPtr  <= PTR_RST;
      q.dstPtr  <= PTR_RST;
      q.intMask <= INTMASK_RST;
    end else begin
      q <= d;
    end
  end

  assign busRdData = q.busRdData;
  assign sylReq    = q.sylReq;
  assign memRdReq  = q.memRdReq;
  assign memRdAddr = q.memRdAddr;
  assign memWrEn   = q.memWrEn;
  assign memWrAddr = q.memWrAddr;
  assign memWrData = q.memWrData;
  assign irq       = q.irq;

  // ****************************************************
  // checks
  // ****************************************************
  chk_protect_abort: assert property (@(posedge ref_clk) disable iff (!nrst)
    (q.st == ST_RDW && memRdValid && memRdProtect)
      |=> (q.st == ST_IDLE && q.intStat[INT_PROTECT]) ##1 q.irq == q.intMask[INT_PROTECT])
    else $error("protect did not abort with interrupt");

  chk_numeric_zone: assert property (@(posedge ref_clk) disable iff (!nrst)
    (q.memWrEn && q.op == OP_MOVE_NUMERIC && q.dst8) |-> q.memWrData[7:4] == ZONE_NUMERIC_8)
    else $error("numeric move zone not forced");

  chk_insert_zero: assert property (@(posedge ref_clk) disable iff (!nrst)
    (q.st == ST_RDW && memRdValid && !memRdProtect && !q.rdDst && q.op == OP_MOVE_WITH_INSERT
      && !q.float && memRdData[3:0] == 4'h0)
      |=> q.memWrEn && q.memWrData == $past(q.arg[0]) && !q.float)
    else $error("zero digit did not insert");

  chk_float_sign: assert property (@(posedge ref_clk) disable iff (!nrst)
    (q.st == ST_RDW && memRdValid && !memRdProtect && !q.rdDst && q.op == OP_MOVE_WITH_FLOAT
      && !q.float && memRdData[3:0] != 4'h0)
      |=> q.float && q.memWrEn
        && q.memWrData == ($past(q.extSign) ? $past(q.arg[1]) : $past(q.arg[2])))
    else $error("float sign character wrong");

  chk_skip_source: assert property (@(posedge ref_clk) disable iff (!nrst)
    (q.st == ST_EXEC && q.op == OP_SKIP_FORWARD_SOURCE)
      |=> q.srcPtr == $past(q.srcPtr) + $past(q.count))
    else $error("forward source skip wrong");

  chk_skip_back: assert property (@(posedge ref_clk) disable iff (!nrst)
    (q.st == ST_EXEC && q.op == OP_SKIP_REVERSE_SOURCE)
      |=> q.srcPtr == $past(q.srcPtr) - $past(q.count))
    else $error("reverse source skip wrong");

  chk_dest_skip: assert property (@(posedge ref_clk) disable iff (!nrst)
    (q.st == ST_EXEC && q.op == OP_SKIP_REVERSE_DESTINATION)
      |=> q.dstPtr == $past(q.dstPtr) - $past(q.count))
    else $error("reverse destination skip wrong");

  chk_float_reset: assert property (@(posedge ref_clk) disable iff (!nrst)
    (q.st == ST_EXEC && q.op == OP_RESET_FLOAT)
      |=> !q.float && !q.memWrEn && $stable(q.dstPtr) && $stable(q.srcPtr))
    else $error("reset float changed more than float");

  chk_end_float: assert property (@(posedge ref_clk) disable iff (!nrst)
    (q.st == ST_EXEC && q.op == OP_END_FLOAT && q.float) |=> !q.float && !q.memWrEn)
    else $error("end float with float set wrote");

  chk_overpunch_zone: assert property (@(posedge ref_clk) disable iff (!nrst)
    (q.memWrEn && q.op == OP_INSERT_OVERPUNCH) |-> q.memWrData[7:4] == ZONE_OVERPUNCH)
    else $error("overpunch zone wrong");

  chk_end_edit: assert property (@(posedge ref_clk) disable iff (!nrst)
    (q.st == ST_OPC && sylValid && sylData == OP_END_EDIT)
      |=> q.st == ST_IDLE && !q.sylReq && q.intStat[INT_ENDEDIT])
    else $error("end edit did not terminate");

endmodule

/* File: tb/emo_partner.sv */
// partner model: program syllable source and string memory with protect marks
`timescale 1ns/10ps
module emo_partner (
  // clock, reset and knobs
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic [1:0]  lat,
  input  wire logic [19:0] protAddr,
  input  wire logic        protEn,
  // syllable stream
  input  wire logic        sylReq,
  output logic             sylValid,
  output logic      [7:0]  sylData,
  // string memory
  input  wire logic        memRdReq,
  input  wire logic [19:0] memRdAddr,
  output logic             memRdValid,
  output logic      [7:0]  memRdData,
  output logic             memRdProtect,
  input  wire logic        memWrEn,
  input  wire logic [19:0] memWrAddr,
  input  wire logic [7:0]  memWrData,
  output logic             memWrAck,
  output logic             memWrProtect
);
  logic [7:0]  mem [256];
  logic [7:0]  prog [256];
  int          pLen;
  logic [7:0]  pIdx;
  logic [19:0] rA;
  logic [19:0] wA;
  logic [7:0]  wD;
  int          rC;
  int          wC;

  // released lines carry the inverted index or toggle so a stale value is never mistaken for data
  assign sylValid = nrst && (int'(pIdx) < pLen);
  assign sylData  = sylValid ? prog[pIdx] : ~pIdx;

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pIdx         <= 8'h00;
      rC           <= 0;
      wC           <= 0;
      memRdValid   <= 1'b0;
      memRdData    <= 8'h00;
      memRdProtect <= 1'b0;
      memWrAck     <= 1'b0;
      memWrProtect <= 1'b0;
    end else begin
      memRdValid   <= 1'b0;
      memWrAck     <= 1'b0;
      memRdData    <= ~memRdData;
      memRdProtect <= ~memRdProtect;
      memWrProtect <= ~memWrProtect;
      if (sylReq && sylValid)
        pIdx <= pIdx + 8'h01;
      rC <= memRdReq ? int'(lat) + 1 : (rC > 0 ? rC - 1 : 0);
      wC <= memWrEn ? int'(lat) + 1 : (wC > 0 ? wC - 1 : 0);
      if (memRdReq)
        rA <= memRdAddr;
      if (memWrEn) begin
        wA <= memWrAddr;
        wD <= memWrData;
      end
      if (rC == 1) begin
        memRdValid   <= 1'b1;
        memRdData    <= mem[rA[7:0]];
        memRdProtect <= protEn && rA == protAddr;
      end
      if (wC == 1) begin
        memWrAck     <= 1'b1;
        memWrProtect <= protEn && wA == protAddr;
        if (!(protEn && wA == protAddr))
          mem[wA[7:0]] <= wD;
      end
    end
  end
endmodule

/* File: tb/edit_micro_operator_engine_test.sv */
// self-checking bench: edit engine against a behavioural string model
`timescale 1ns/10ps
module edit_micro_operator_engine_test
  import emo_pkg::*;
();
  // ****************
  // signals and model state
  // ****************
  logic        ref_clk, nrst, busWrStb, busRdStb, protEn, irq;
  logic        sylReq, sylValid, memRdReq, memRdValid, memRdProtect;
  logic        memWrEn, memWrAck, memWrProtect;
  logic [1:0]  lat;
  logic [4:0]  busAddr;
  logic [31:0] busWrData, busRdData, s;
  logic [7:0]  sylData, memRdData, memWrData;
  logic [19:0] memRdAddr, memWrAddr, protAddr;
  logic [7:0]  mm [256];
  logic [31:0] seed = 32'h542A;
  int          sp, dp, rep, k, r, errorCnt, nTests;
  bit          flt, xs, d8, tbl, f;

  emo_engine i_emo_engine (.ref_clk, .nrst, .busAddr, .busWrData, .busWrStb, .busRdStb,
    .busRdData, .sylReq, .sylValid, .sylData, .memRdReq, .memRdAddr, .memRdValid,
    .memRdData, .memRdProtect, .memWrEn, .memWrAddr, .memWrData, .memWrAck,
    .memWrProtect, .irq);
  emo_partner i_emo_partner (.ref_clk, .nrst, .lat, .protAddr, .protEn, .sylReq,
    .sylValid, .sylData, .memRdReq, .memRdAddr, .memRdValid, .memRdData, .memRdProtect,
    .memWrEn, .memWrAddr, .memWrData, .memWrAck, .memWrProtect);

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // ****************
  // helpers
  // ****************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [7:0] srcCh();
    sp++;
    return mm[8'(sp - 1)];
  endfunction
  function automatic logic [7:0] numOf(input logic [7:0] c);
    return {d8 ? 4'hF : 4'h0, c[3:0]};
  endfunction
  task automatic wrCh(input logic [7:0] c);
    mm[dp[7:0]] = c;
    dp++;
  endtask
  task automatic endSim();
    $display("tests %0d errors %0d", nTests, errorCnt);
    if (errorCnt == 0 && nTests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      errorCnt++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // strobe drops one edge after rising, so back-to-back calls never clash
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    busAddr   <= a;
    busWrData <= d;
    busWrStb  <= 1'b1;
    @(posedge ref_clk);
    busWrStb <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    busAddr  <= a;
    busRdStb <= 1'b1;
    @(posedge ref_clk);
    busRdStb <= 1'b0;
    @(posedge ref_clk);
    d = busRdData;
  endtask
  task automatic push(input logic [7:0] b);
    i_emo_partner.prog[i_emo_partner.pLen] = b;
    i_emo_partner.pLen++;
  endtask
  task automatic modelOp(input logic [7:0] op, input int n, input logic [7:0] a1, a2, a3);
    logic [7:0] c;
    case (op)
      8'hD7: repeat (n) wrCh(srcCh());
      8'hD6: repeat (n) wrCh(numOf(srcCh()));
      8'hD0: repeat (n) begin
        c = srcCh();
        if (flt || c[3:0] != 4'h0) begin
          flt = 1'b1;
          wrCh(numOf(c));
        end else
          wrCh(a1);
      end
      8'hD1: repeat (n) begin
        c = srcCh();
        if (!flt && c[3:0] == 4'h0)
          wrCh(a1);
        else begin
          if (!flt)
            wrCh(xs ? a2 : a3);
          flt = 1'b1;
          wrCh(numOf(c));
        end
      end
      8'hD2: sp += n;
      8'hD3: sp -= n;
      8'hDA: dp += n;
      8'hDB: dp -= n;
      8'hD4: flt = 1'b0;
      8'hD5: if (flt)
          flt = 1'b0;
        else
          wrCh(xs ? a1 : a2);
      8'hDC: repeat (n) wrCh(a1);
      8'hDD: repeat (n) wrCh(flt ? a2 : a1);
      8'hD9: wrCh(xs ? a1 : a2);
      8'hD8: if (xs)
          mm[8'(dp - 1)][7:4] = 4'hD;
      default: ;
    endcase
  endtask
  task automatic emit(input logic [7:0] op, input int n, input logic [7:0] a1, a2, a3);
    int na;
    na = op == 8'hD1 ? 3 : (op inside {8'hD5, 8'hD9, 8'hDD} ? 2 : (op inside {8'hD0, 8'hDC}));
    push(op);
    if (tbl && op inside {[8'hD0 : 8'hD3], 8'hD6, 8'hD7, [8'hDA : 8'hDD]})
      push(8'(n));
    if (na > 0)
      push(a1);
    if (na > 1)
      push(a2);
    if (na > 2)
      push(a3);
    modelOp(op, n, a1, a2, a3);
  endtask
  task automatic start(input bit fl);
    int i;
    wr(REG_REPEAT, rep);
    wr(REG_CTRL, {27'h0, fl, xs, d8, tbl, 1'b1});
    s = 32'h1;
    for (i = 0; i < 500 && s[0] !== 1'b0; i++)
      rd(REG_STATUS, s);
    if (s[0] !== 1'b0) begin
      errorCnt++;
      $display("ERROR %0t: engine stuck busy", $time);
      endSim();
    end
    for (i = 0; i < 256; i++)
      chk(i_emo_partner.mem[i], mm[i]);
  endtask

  // ****************
  // main sequence
  // ****************
  initial begin
    {busWrStb, busRdStb, protEn, nrst} = '0;
    {busAddr, busWrData, lat, protAddr} = '0;
    {errorCnt, nTests, i_emo_partner.pLen} = '0;
    for (k = 0; k < 256; k++) begin
      mm[k] = 8'(rnd()) & 8'hF3;
      i_emo_partner.mem[k] = mm[k];
    end
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    wr(5'h1C, 32'hFFFF);
    for (k = 0; k < 32; k += 4) begin
      rd(5'(k), s);
      chk(s, 32'h0);
    end
    $display("test reset done");
    sp = 40;
    dp = 128;
    wr(REG_SRCPTR, sp);
    wr(REG_DSTPTR, dp);
    for (r = 0; r < 5; r++) begin
      tbl = r < 4;
      s = rnd();
      {xs, d8, flt} = s[2:0];
      f = flt;
      for (k = 0; k < 14; k++) begin
        s = rnd();
        rep = s[1:0];
        lat <= s[3:2];
        f = tbl ? f : flt;
        emit(8'hD0 + 8'((k + r) % 14), rep, s[15:8], s[23:16], s[31:24]);
        if (!tbl)
          start(f);
      end
      if (tbl) begin
        emit(OP_END_EDIT, 0, 0, 0, 0);
        start(f);
      end
      rd(REG_SRCPTR, s);
      chk(s, sp & 32'hFFFFF);
      rd(REG_DSTPTR, s);
      chk(s, dp & 32'hFFFFF);
      rd(REG_CTRL, s);
      chk(s[4], flt);
      $display("test round %0d done", r);
    end
    // an opcode outside the edit set must stop the engine and flag it
    push(8'h00);
    start(flt);
    rd(REG_INTSTAT, s);
    chk(s[2], 1'b1);
    chk(s[3], 1'b1);
    chk(irq, 1'b0);
    wr(REG_INTMASK, 32'h4);
    @(posedge ref_clk);
    chk(irq, 1'b1);
    wr(REG_INTSTAT, 32'hF);
    @(posedge ref_clk);
    chk(irq, 1'b0);
    $display("test interrupt done");
    protEn <= 1'b1;
    protAddr <= 20'(sp + 1);
    wr(REG_INTMASK, 32'h1);
    tbl = 1'b1;
    push(OP_MOVE_CHARACTERS);
    push(8'h03);
    push(OP_INSERT_UNCONDITIONAL);
    push(8'h02);
    push(8'h5A);
    push(OP_END_EDIT);
    wrCh(mm[sp[7:0]]);
    start(flt);
    rd(REG_INTSTAT, s);
    chk(s[0], 1'b1);
    chk(irq, 1'b1);
    // leftover insert hits a protected destination: abort, table not continued
    protAddr <= 20'(dp);
    wr(REG_INTSTAT, 32'hF);
    start(flt);
    rd(REG_INTSTAT, s);
    chk(s[2:0], 3'h1);
    $display("test protect done");
    endSim();
  end
endmodule
